//--- rtl/ces_sequencer.sv
`timescale 1ns/1ps
`include "ces_consts.svh"
// Functional notes
// RL1 - Save status, set supervisor, clear trace
// RL2 - Interrupt: clear master, mask gets level
// RL3 - Faults vector internally, interrupts via acknowledge
// RL4 - Acknowledge in own space, level in address
// RL5 - Single stack, frame word-aligned at top
// RL6 - Handler fetched at base plus four times vector
// RL7 - Vector table aligned to one megabyte
// RL8 - Processing ends when opcode fetch issued
// RL9 - 256 vectors, 192 user interrupt vectors
// RL10 - No interrupt sampling in first handler instruction
// RL11 - Vector 0 stack, vector 1 program counter
// RL12 - Vectors 2-5 and 8 stack fault address
// RL13 - Vectors 10, 11, 14 stack fault address
// RL14 - Trace, debug, interrupts, traps stack next address
// RL15 - Autovector levels 1-7 give vectors 25-31
// RL16 - Traps 0-15 give vectors 32-47
// RL17 - Frame: format/vector plus status, then PC
// RL18 - Format 4-7 from stack low bits
// RL19 - Fault status only for access/address errors
// RL20 - Vector field internal or from peripheral
// RL21 - Low 20 base bits read zero
// RL22 - Status bit 15 is trace, cleared
// RL23 - Status longword at new stack, PC above
module ces_sequencer
  import ces_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        excReq,
  input  wire ces_exc_t    excType,
  input  wire logic [3:0]  excTrapNum,
  input  wire logic [3:0]  excFaultStatus,
  input  wire logic [2:0]  irqLevel,
  input  wire logic [31:0] faultPc,
  input  wire logic [31:0] nextPc,
  input  wire logic [15:0] processorStatusWordIn,
  input  wire logic [31:0] stackPointerRegIn,
  input  wire logic        vectorBaseWe,
  input  wire logic [31:0] vectorBaseWdata,
  input  wire logic        instrRetire,
  output logic             memReq,
  output logic             memWe,
  output logic             memAckSpace,
  output logic [31:0]      memAddr,
  output logic [31:0]      memWdata,
  input  wire logic        memAck,
  input  wire logic        memErr,
  input  wire logic        memAutoVec,
  input  wire logic [31:0] memRdata,
  output logic [15:0]      processorStatusWordOut,
  output logic             processorStatusWordUpd,
  output logic [31:0]      stackPointerRegOut,
  output logic             stackPointerRegUpd,
  output logic [31:0]      handlerPc,
  output logic             handlerPcUpd,
  output logic [31:0]      vectorBaseReg,
  output logic             excBusy,
  output logic             excDone,
  output logic             irqSampleInhibit
);

  ces_seq_t q;
  ces_seq_t n;
  ces_vec_if vif ();

  ces_vector_calc u_calc (
    .vif (vif.calc)
  );

  assign vif.excType  = excType;
  assign vif.trapNum  = excTrapNum;
  assign vif.irqLevel = irqLevel;

  logic        start;
  logic [31:0] alignedSp;
  logic [31:0] vecAddr;
  logic [31:0] frameWord;
  logic [7:0]  iackVec;
  logic [7:0]  periphByte;

  assign start     = excReq && (q.st == CES_ST_IDLE);
  assign alignedSp = {stackPointerRegIn[31:2], 2'h0} - `CES_FRAME_BYTES; // RL5 RL18
  assign vecAddr   = {q.vbrHi, `CES_VBR_LOW_ZERO} | {`CES_VEC_PAD, q.vec, 2'h0}; // RL6 RL7
  // Format in 31:28, fault status split around the vector, status word low.
  // The stacked status word is the copy taken before supervisor entry, so a handler sees trace.
  assign frameWord = {q.fmt, q.fs[3:2], q.vec, q.fs[1:0], q.srSaved}; // RL17 RL20
  assign periphByte = memRdata[7:0];

  // An autovector answer or a failed acknowledge overrides the returned byte.
  always_comb begin
    if (memErr) begin
      iackVec = `CES_VEC_SPURIOUS; // RL14
    end else if (memAutoVec) begin
      iackVec = vif.autoVector; // RL15
    end else begin
      iackVec = memRdata[7:0]; // RL3 RL9 RL20
    end
  end

  always_comb begin
    n        = q;
    n.srUpd  = 1'b0;
    n.spUpd  = 1'b0;
    n.pcUpd  = 1'b0;
    n.done   = 1'b0;
    if (vectorBaseWe) begin
      n.vbrHi = vectorBaseWdata[31:`CES_VBR_LSB]; // RL21
    end
    if (q.inhibit && instrRetire && (q.st == CES_ST_IDLE)) begin
      n.inhibit = 1'b0; // RL10
    end
    case (q.st)
      CES_ST_IDLE: begin
        if (excReq) begin
          n.srSaved            = processorStatusWordIn; // RL1 RL17
          n.sr                 = processorStatusWordIn; // RL1
          n.sr[`CES_SR_TRACE]  = 1'b0; // RL1 RL22
          n.sr[`CES_SR_SUPER]  = 1'b1; // RL1
          if (vif.isIrq) begin
            n.sr[`CES_SR_MASTER]                   = 1'b0; // RL2
            n.sr[`CES_SR_IPM_HI:`CES_SR_IPM_LO]    = irqLevel; // RL2
          end
          n.srUpd   = 1'b1;
          n.origSp  = stackPointerRegIn;
          n.sp      = alignedSp; // RL5
          n.fmt     = `CES_FMT_BASE + {2'h0, stackPointerRegIn[1:0]}; // RL18
          n.fs      = vif.keepFs ? excFaultStatus : `CES_FS_NONE; // RL19
          n.vec     = vif.vector; // RL3
          n.pc      = vif.stackFault ? faultPc : nextPc; // RL12 RL13 RL14
          n.level   = irqLevel;
          n.inhibit = 1'b1; // RL10
          if (vif.isIrq) begin
            n.st       = CES_ST_INTERRUPT_ACK_CYCLE;
            n.ackSpace = 1'b1;
            n.memAddr  = `CES_INTERRUPT_ACK_CYCLE_ADDR | {`CES_INTERRUPT_ACK_CYCLE_PAD, irqLevel, 2'h0}; // RL4
          end else begin
            n.st       = CES_ST_PUSH_SR;
            n.memAddr  = alignedSp; // RL23
          end
        end
      end
      CES_ST_RST_SP: begin
        n.memAddr = {q.vbrHi, `CES_VBR_LOW_ZERO} | {`CES_VEC_PAD, `CES_VEC_INIT_SP, 2'h0};
        if (memAck) begin
          n.sp      = memRdata; // RL11
          n.spUpd   = 1'b1;
          n.st      = CES_ST_RST_PC;
          n.memAddr = {q.vbrHi, `CES_VBR_LOW_ZERO} | {`CES_VEC_PAD, `CES_VEC_INIT_PC, 2'h0};
        end
      end
      CES_ST_RST_PC: begin
        if (memAck) begin
          n.handler = memRdata; // RL11
          // Reset also ends in a handler, so its first instruction is shielded too.
          n.inhibit = 1'b1; // RL10
          n.memAddr = memRdata;
          n.st      = CES_ST_OP_FET;
        end
      end
      CES_ST_INTERRUPT_ACK_CYCLE: begin
        if (memAck || memErr) begin
          n.vec      = iackVec; // RL20
          n.ackSpace = 1'b0;
          n.memAddr  = q.sp; // RL23
          n.st       = CES_ST_PUSH_SR;
        end
      end
      CES_ST_PUSH_SR: begin
        if (memAck) begin
          n.memAddr  = q.sp + `CES_LONG_BYTES; // RL23
          n.memWdata = q.pc; // RL17
          n.st       = CES_ST_PUSH_PC;
        end else begin
          n.memWdata = frameWord; // RL17
        end
      end
      CES_ST_PUSH_PC: begin
        if (memAck) begin
          n.spUpd   = 1'b1; // RL18
          n.memAddr = vecAddr; // RL6
          n.st      = CES_ST_VEC_FET;
        end
      end
      CES_ST_VEC_FET: begin
        if (memAck) begin
          n.handler = memRdata; // RL6
          n.memAddr = memRdata;
          n.st      = CES_ST_OP_FET;
        end
      end
      CES_ST_OP_FET: begin
        if (memAck) begin
          n.pcUpd = 1'b1;
          n.done  = 1'b1; // RL8
          n.st    = CES_ST_IDLE;
        end
      end
      default: n.st = CES_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q <= CES_SEQ_RESET;
    end else begin
      q <= n;
    end
  end

  // The frame word needs the vector, so it is loaded one cycle into the push.
  assign memReq      = (q.st != CES_ST_IDLE) &&
                       !((q.st == CES_ST_PUSH_SR) && (q.memWdata != frameWord));
  assign memWe       = (q.st == CES_ST_PUSH_SR) || (q.st == CES_ST_PUSH_PC);
  assign memAckSpace = q.ackSpace; // RL4
  assign memAddr     = q.memAddr;
  assign memWdata    = q.memWdata;

  assign processorStatusWordOut = q.sr;
  assign processorStatusWordUpd = q.srUpd;
  assign stackPointerRegOut     = q.sp;
  assign stackPointerRegUpd     = q.spUpd;
  assign handlerPc              = q.handler;
  assign handlerPcUpd           = q.pcUpd;
  assign vectorBaseReg          = {q.vbrHi, `CES_VBR_LOW_ZERO}; // RL21
  assign excBusy                = (q.st != CES_ST_IDLE);
  assign excDone                = q.done;
  assign irqSampleInhibit       = q.inhibit; // RL10

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence seqVecTaken;
    (q.st == CES_ST_VEC_FET) && memAck;
  endsequence
  sequence seqOpIssued;
    (q.st == CES_ST_OP_FET) && (memAddr == handlerPc) ##[1:1000] excDone;
  endsequence
  sequence seqInitStackTaken;
    (q.st == CES_ST_RST_SP) && memAck;
  endsequence

  AST_ENTRY_SR: assert property (start |=> processorStatusWordUpd && // RL1
      !processorStatusWordOut[15] && processorStatusWordOut[13])
    else $error("status word not forced on entry");
  AST_IRQ_MASK: assert property (start && (excType == CES_EXC_IRQ) |=> // RL2
      !processorStatusWordOut[12] && processorStatusWordOut[10:8] == $past(irqLevel))
    else $error("interrupt mask or master bit wrong");
  AST_INTERRUPT_ACK_CYCLE_ADDR: assert property ((q.st == CES_ST_INTERRUPT_ACK_CYCLE) |-> memAckSpace && // RL4
      !memWe && memAddr[4:2] == q.level)
    else $error("acknowledge cycle malformed");
  AST_FRAME_ALIGN: assert property ((q.st == CES_ST_PUSH_SR) |-> // RL5
      memAddr[1:0] == 2'h0 && memAddr == {q.origSp[31:2], 2'h0} - `CES_FRAME_BYTES)
    else $error("frame not aligned");
  AST_FORMAT: assert property ((q.st == CES_ST_PUSH_SR) && memReq |-> // RL18
      memWdata[31:28] == 4'h4 + {2'h0, q.origSp[1:0]})
    else $error("format field wrong");
  AST_PC_ABOVE: assert property ((q.st == CES_ST_PUSH_SR) && memAck |=> // RL23
      (q.st == CES_ST_PUSH_PC) && memAddr == $past(memAddr) + 32'h0000_0004 &&
      memWdata == q.pc)
    else $error("PC longword misplaced");
  AST_VEC_ADDR: assert property ((q.st == CES_ST_VEC_FET) |-> // RL6 RL7
      memAddr[31:20] == vectorBaseReg[31:20] && memAddr[19:0] == {10'h000, q.vec, 2'h0})
    else $error("vector fetch address wrong");
  AST_DONE: assert property (seqVecTaken |=> seqOpIssued) // RL8
    else $error("handler opcode fetch not issued");
  AST_INHIBIT: assert property (excDone |-> irqSampleInhibit) // RL10
    else $error("interrupts sampled in handler entry");
  AST_FS_ZERO: assert property ((q.st == CES_ST_PUSH_SR) && memReq && // RL19
      q.vec != 8'h02 && q.vec != 8'h03 |-> {memWdata[27:26], memWdata[17:16]} == 4'h0)
    else $error("fault status not zero");
  AST_VBR_LOW: assert property (vectorBaseWe |=> // RL7 RL21
      vectorBaseReg == ($past(vectorBaseWdata) & 32'hFFF0_0000))
    else $error("vector base not written or low bits nonzero");
  AST_RST_SP_ADDR: assert property ((q.st == CES_ST_RST_SP) |-> // RL11
      memReq && !memWe && memAddr == vectorBaseReg)
    else $error("initial stack read address wrong");
  AST_RST_PC_ADDR: assert property ((q.st == CES_ST_RST_PC) |-> // RL11
      memReq && !memWe && memAddr == (vectorBaseReg | 32'h0000_0004))
    else $error("initial program counter read address wrong");
  AST_RST_ORDER: assert property (seqInitStackTaken |=> // RL11
      (q.st == CES_ST_RST_PC) && stackPointerRegUpd &&
      stackPointerRegOut == $past(memRdata))
    else $error("initial stack pointer not loaded");
  AST_SR_COPY: assert property (start |=> // RL1
      q.srSaved == $past(processorStatusWordIn))
    else $error("status word copy not kept");
  AST_FRAME_SR: assert property ((q.st == CES_ST_PUSH_SR) && memReq |-> // RL1 RL17
      memWdata[15:0] == q.srSaved)
    else $error("stacked status word is not the saved copy");
  AST_STACK_UPD: assert property ((q.st == CES_ST_PUSH_PC) && memAck |=> // RL5 RL18
      stackPointerRegUpd && stackPointerRegOut == {q.origSp[31:2], 2'h0} - `CES_FRAME_BYTES)
    else $error("stack pointer not lowered past the frame");
  // Acknowledge outcomes: peripheral byte, autovector and spurious answer.
  AST_INTERRUPT_ACK_CYCLE_VEC: assert property ((q.st == CES_ST_INTERRUPT_ACK_CYCLE) && memAck && // RL3 RL20
      !memErr && !memAutoVec |=> q.vec == $past(periphByte))
    else $error("peripheral vector not taken");
  AST_AUTOVEC: assert property ((q.st == CES_ST_INTERRUPT_ACK_CYCLE) && memAck && // RL15
      !memErr && memAutoVec |=> q.vec == `CES_VEC_AUTO_BASE + {5'h00, q.level})
    else $error("autovector wrong");
  AST_SPURIOUS: assert property ((q.st == CES_ST_INTERRUPT_ACK_CYCLE) && memErr |=> // RL14
      q.vec == `CES_VEC_SPURIOUS)
    else $error("spurious vector not used");
  AST_EXIT: assert property (excDone |-> !excBusy && handlerPcUpd) // RL8
    else $error("exception processing did not end cleanly");

endmodule : ces_sequencer

//--- rtl/ces_consts.svh
`ifndef CES_CONSTS_SVH
`define CES_CONSTS_SVH

// Vector numbers.
`define CES_VEC_INIT_SP    8'h00
`define CES_VEC_INIT_PC    8'h01
`define CES_VEC_ACCESS     8'h02
`define CES_VEC_ADDRESS    8'h03
`define CES_VEC_ILLEGAL    8'h04
`define CES_VEC_DIVZERO    8'h05
`define CES_VEC_PRIV       8'h08
`define CES_VEC_TRACE      8'h09
`define CES_VEC_LINE_A     8'h0A
`define CES_VEC_LINE_F     8'h0B
`define CES_VEC_DEBUG      8'h0C
`define CES_VEC_FORMAT     8'h0E
`define CES_VEC_UNINIT     8'h0F
`define CES_VEC_SPURIOUS   8'h18
`define CES_VEC_AUTO_BASE  8'h18
`define CES_VEC_TRAP_BASE  8'h20
`define CES_VEC_USER_FIRST 8'h40

// Vector table size in bytes.
`define CES_VTAB_BYTES     32'h0000_0400

// Status word bit positions.
`define CES_SR_TRACE       15
`define CES_SR_SUPER       13
`define CES_SR_MASTER      12
`define CES_SR_IPM_HI      10
`define CES_SR_IPM_LO      8

// Vector base alignment: bits below this index are not implemented.
`define CES_VBR_LSB        20
`define CES_VBR_LOW_ZERO   20'h0_0000

// Stack frame.
`define CES_FMT_BASE       4'h4
`define CES_FRAME_BYTES    32'h0000_0008
`define CES_LONG_BYTES     32'h0000_0004

// Fault status codes.
`define CES_FS_IFETCH      4'h4
`define CES_FS_OPWRITE     4'h8
`define CES_FS_WRPROT      4'h9
`define CES_FS_OPREAD      4'hC
`define CES_FS_NONE        4'h0

// Acknowledge address space base; the level sits in bits 4:2.
`define CES_INTERRUPT_ACK_CYCLE_ADDR      32'hFFFF_FFE0
`define CES_INTERRUPT_ACK_CYCLE_PAD       27'h000_0000
`define CES_VEC_PAD        22'h00_0000

`endif

//--- rtl/ces_pkg.sv
package ces_pkg;

  typedef enum logic [3:0] {
    CES_EXC_ACCESS  = 4'b0000,
    CES_EXC_ADDRESS = 4'b0001,
    CES_EXC_ILLEGAL = 4'b0010,
    CES_EXC_DIVZERO = 4'b0011,
    CES_EXC_PRIV    = 4'b0100,
    CES_EXC_TRACE   = 4'b0101,
    CES_EXC_LINE_A  = 4'b0110,
    CES_EXC_LINE_F  = 4'b0111,
    CES_EXC_DEBUG   = 4'b1000,
    CES_EXC_FORMAT  = 4'b1001,
    CES_EXC_TRAP    = 4'b1010,
    CES_EXC_IRQ     = 4'b1011
  } ces_exc_t;

  typedef enum logic [3:0] {
    CES_ST_IDLE     = 4'b0000,
    CES_ST_RST_SP   = 4'b0001,
    CES_ST_RST_PC   = 4'b0010,
    CES_ST_INTERRUPT_ACK_CYCLE     = 4'b0011,
    CES_ST_PUSH_SR  = 4'b0100,
    CES_ST_PUSH_PC  = 4'b0101,
    CES_ST_VEC_FET  = 4'b0110,
    CES_ST_OP_FET   = 4'b0111
  } ces_state_t;

  typedef struct packed {
    ces_state_t  st;
    logic [15:0] sr;
    logic [15:0] srSaved;
    logic [31:0] sp;
    logic [31:0] origSp;
    logic [3:0]  fmt;
    logic [3:0]  fs;
    logic [7:0]  vec;
    logic [31:0] pc;
    logic [11:0] vbrHi;
    logic [31:0] handler;
    logic [2:0]  level;
    logic        inhibit;
    logic        ackSpace;
    logic [31:0] memAddr;
    logic [31:0] memWdata;
    logic        srUpd;
    logic        spUpd;
    logic        pcUpd;
    logic        done;
  } ces_seq_t;

  localparam ces_seq_t CES_SEQ_RESET = '{st: CES_ST_RST_SP, default: '0};

endpackage : ces_pkg

//--- rtl/ces_vec_if.sv
`timescale 1ns/1ps
interface ces_vec_if;
  import ces_pkg::*;
  ces_exc_t   excType;
  logic [3:0] trapNum;
  logic [2:0] irqLevel;
  logic [7:0] vector;
  logic [7:0] autoVector;
  logic       stackFault;
  logic       keepFs;
  logic       isIrq;

  modport calc (input excType, input trapNum, input irqLevel,
                output vector, output autoVector, output stackFault,
                output keepFs, output isIrq);
  modport seq  (output excType, output trapNum, output irqLevel,
                input vector, input autoVector, input stackFault,
                input keepFs, input isIrq);
endinterface : ces_vec_if

//--- rtl/ces_vector_calc.sv
`timescale 1ns/1ps
`include "ces_consts.svh"
module ces_vector_calc
  import ces_pkg::*;
(
  ces_vec_if.calc vif
);

  always_comb begin
    vif.stackFault = 1'b1;
    vif.keepFs     = 1'b0;
    vif.isIrq      = 1'b0;
    vif.vector     = `CES_VEC_ILLEGAL;
    case (vif.excType)
      CES_EXC_ACCESS: begin
        vif.vector = `CES_VEC_ACCESS; // RL12
        vif.keepFs = 1'b1; // RL19
      end
      CES_EXC_ADDRESS: begin
        vif.vector = `CES_VEC_ADDRESS; // RL12
        vif.keepFs = 1'b1; // RL19
      end
      CES_EXC_ILLEGAL: vif.vector = `CES_VEC_ILLEGAL; // RL12
      CES_EXC_DIVZERO: vif.vector = `CES_VEC_DIVZERO; // RL12
      CES_EXC_PRIV:    vif.vector = `CES_VEC_PRIV; // RL12
      CES_EXC_LINE_A:  vif.vector = `CES_VEC_LINE_A; // RL13
      CES_EXC_LINE_F:  vif.vector = `CES_VEC_LINE_F; // RL13
      CES_EXC_FORMAT:  vif.vector = `CES_VEC_FORMAT; // RL13
      CES_EXC_TRACE: begin
        vif.vector     = `CES_VEC_TRACE; // RL14
        vif.stackFault = 1'b0;
      end
      CES_EXC_DEBUG: begin
        vif.vector     = `CES_VEC_DEBUG; // RL14
        vif.stackFault = 1'b0;
      end
      CES_EXC_TRAP: begin
        vif.vector     = `CES_VEC_TRAP_BASE + {4'h0, vif.trapNum}; // RL16
        vif.stackFault = 1'b0; // RL14
      end
      CES_EXC_IRQ: begin
        // The real vector arrives later from the acknowledge cycle.
        vif.vector     = `CES_VEC_SPURIOUS;
        vif.stackFault = 1'b0; // RL14
        vif.isIrq      = 1'b1;
      end
      default: vif.vector = `CES_VEC_ILLEGAL;
    endcase
  end

  assign vif.autoVector = `CES_VEC_AUTO_BASE + {5'h00, vif.irqLevel}; // RL15

endmodule : ces_vector_calc

//--- tb/ces_mem_model.sv
`timescale 1ns/1ps
// System memory plus the interrupting peripheral, answering after ackDelay cycles.
module ces_mem_model (
  input  wire logic        mclk,
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic        memAckSpace,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  output logic             memAck,
  output logic             memErr,
  output logic             memAutoVec,
  output logic [31:0]      memRdata,
  input  wire logic [3:0]  ackDelay,
  input  wire logic [1:0]  iackMode,
  input  wire logic [7:0]  iackVec
);
  logic [31:0] store [logic [31:0]];
  logic [33:0] accessLog [$];
  logic [3:0]  waitCnt;

  initial begin
    memAck = 1'b0;
    memErr = 1'b0;
    memAutoVec = 1'b0;
    memRdata = 32'hA5A5_A5A5;
    waitCnt = 4'h0;
  end

  // Read data is scrambled every cycle outside an answer so stale values never match.
  always @(negedge mclk) begin
    if (memAck || memErr) waitCnt = 4'h0;
    memAck = 1'b0;
    memErr = 1'b0;
    memAutoVec = 1'b0;
    if (memReq && waitCnt >= ackDelay) begin
      if (memAckSpace) begin
        memErr = (iackMode == 2'h2);
        memAck = (iackMode != 2'h2);
        memAutoVec = (iackMode == 2'h1);
        memRdata = {24'h00_0000, iackVec};
      end else begin
        memAck = 1'b1;
        memRdata = store.exists(memAddr) ? store[memAddr] : ~memAddr;
      end
    end else begin
      waitCnt = waitCnt + {3'h0, memReq};
      memRdata = ~memRdata;
    end
  end

  always @(posedge mclk) begin
    if (memReq && (memAck || memErr)) begin
      if (memWe) store[memAddr] = memWdata;
      accessLog.push_back({memWe, memAckSpace, memAddr});
    end
  end
endmodule : ces_mem_model

//--- tb/cpu_exception_sequencer_tb.sv
`timescale 1ns/1ps
module cpu_exception_sequencer_tb;
  import ces_pkg::*;
  logic mclk, nrst, excReq, vectorBaseWe, instrRetire;
  ces_exc_t excType;
  logic [3:0] excTrapNum, excFaultStatus, ackDelay;
  logic [2:0] irqLevel;
  logic [31:0] faultPc, nextPc, stackPointerRegIn, vectorBaseWdata, memAddr, memWdata;
  logic [15:0] processorStatusWordIn, processorStatusWordOut;
  logic memReq, memWe, memAckSpace, memAck, memErr, memAutoVec;
  logic [31:0] memRdata, stackPointerRegOut, handlerPc, vectorBaseReg;
  logic processorStatusWordUpd, stackPointerRegUpd, handlerPcUpd;
  logic excBusy, excDone, irqSampleInhibit;
  logic [1:0] iackMode;
  logic [7:0] iackVec;
  int failures, samplesChecked;

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  ces_sequencer dut (.*);
  ces_mem_model mem (.*);

  task chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    samplesChecked++;
    if (got !== expv) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, expv, got);
    end
  endtask : chk

  task wait_done;
    for (int n = 0; n < 300 && excDone !== 1'b1; n++) @(negedge mclk);
    chk("done", 32'h0000_0001, {31'h0000_0000, excDone});
    chk("handler upd", 32'h0000_0001, {31'h0000_0000, handlerPcUpd});
    chk("idle", 32'h0000_0000, {31'h0000_0000, excBusy});
  endtask : wait_done

  task end_of_test;
    $display("comparisons %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Stack pointer 2000_1000 plus low bits; the frame therefore always lands at 2000_0FF8.
  task run_exc(input ces_exc_t t, input logic [3:0] trap, input logic [3:0] fs,
               input logic [2:0] lvl, input logic [1:0] spLow, input logic [7:0] vec,
               input bit atFault, input bit fsKept);
    logic [31:0] spNew, vAddr, hnd, w0, pcExp;
    logic [15:0] srExp;
    logic [3:0] fsE;
    int n;
    spNew = 32'h2000_0FF8;
    vAddr = 32'h0010_0000 + {22'h00_0000, vec, 2'h0};
    hnd = 32'h0003_0000 + {22'h00_0000, vec, 2'h0};
    mem.store[vAddr] = hnd;
    mem.store.delete(spNew);
    mem.store.delete(spNew + 32'h0000_0004);
    mem.accessLog.delete();
    excType = t;
    excTrapNum = trap;
    excFaultStatus = fs;
    irqLevel = lvl;
    stackPointerRegIn = {30'h0800_0400, spLow};
    excReq = 1'b1;
    @(negedge mclk);
    excReq = 1'b0;
    chk("busy", 32'h0000_0001, {31'h0000_0000, excBusy});
    chk("status upd", 32'h0000_0001, {31'h0000_0000, processorStatusWordUpd});
    wait_done;
    fsE = fsKept ? fs : 4'h0;
    pcExp = atFault ? faultPc : nextPc;
    srExp = 16'h9715 & 16'h7FFF | 16'h2000;
    if (t == CES_EXC_IRQ) srExp = 16'h9715 & 16'h68FF | 16'h2000 | {5'h00, lvl, 8'h00};
    w0 = {4'h4 + {2'h0, spLow}, fsE[3:2], vec, fsE[1:0], 16'h9715};
    n = mem.accessLog.size();
    chk("frame word", w0, mem.store[spNew]);
    chk("frame pc", pcExp, mem.store[spNew + 32'h0000_0004]);
    chk("stack", spNew, stackPointerRegOut);
    chk("status", {16'h0000, srExp}, {16'h0000, processorStatusWordOut});
    chk("handler", hnd, handlerPc);
    chk("accesses", (t == CES_EXC_IRQ) ? 32'h0000_0005 : 32'h0000_0004, 32'(n));
    chk("vector read", vAddr, mem.accessLog[n - 2][31:0]);
    chk("vector kind", 32'h0000_0000, {30'h0000_0000, mem.accessLog[n - 2][33:32]});
    chk("opcode fetch", hnd, mem.accessLog[n - 1][31:0]);
    chk("opcode kind", 32'h0000_0000, {30'h0000_0000, mem.accessLog[n - 1][33:32]});
    if (t == CES_EXC_IRQ) begin
      chk("ack addr", 32'hFFFF_FFE0 | {27'h000_0000, lvl, 2'h0}, mem.accessLog[0][31:0]);
      chk("ack kind", 32'h0000_0001, {30'h0000_0000, mem.accessLog[0][33:32]});
    end
    chk("inhibit", 32'h0000_0001, {31'h0000_0000, irqSampleInhibit});
    instrRetire = 1'b1;
    @(negedge mclk);
    instrRetire = 1'b0;
    repeat (2) @(negedge mclk);
    chk("inhibit off", 32'h0000_0000, {31'h0000_0000, irqSampleInhibit});
  endtask : run_exc

  task t_reset;
    wait_done;
    chk("reset stack", 32'h2000_2000, stackPointerRegOut);
    chk("reset pc", 32'h0000_8000, handlerPc);
    chk("reset inhibit", 32'h0000_0001, {31'h0000_0000, irqSampleInhibit});
    vectorBaseWdata = 32'h0012_3456;
    vectorBaseWe = 1'b1;
    @(negedge mclk);
    vectorBaseWe = 1'b0;
    @(negedge mclk);
    chk("vector base", 32'h0010_0000, vectorBaseReg);
  endtask : t_reset

  task t_faults;
    ces_exc_t ty[10] = '{CES_EXC_ACCESS, CES_EXC_ADDRESS, CES_EXC_ILLEGAL, CES_EXC_DIVZERO,
                         CES_EXC_PRIV, CES_EXC_TRACE, CES_EXC_LINE_A, CES_EXC_LINE_F,
                         CES_EXC_DEBUG, CES_EXC_FORMAT};
    logic [7:0] vecs[10] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E};
    bit flt[10] = '{1, 1, 1, 1, 1, 0, 1, 1, 0, 1};
    logic [3:0] fsc[4] = '{4'h4, 4'h8, 4'h9, 4'hC};
    for (int i = 0; i < 10; i++) begin
      ackDelay = 4'(i % 3);
      run_exc(ty[i], 4'h0, fsc[i % 4], 3'h0, 2'(i), vecs[i], flt[i], i < 2);
    end
  endtask : t_faults

  task t_traps;
    for (int i = 0; i < 16; i++)
      run_exc(CES_EXC_TRAP, 4'(i), 4'hC, 3'h0, 2'h3, 8'h20 + 8'(i), 0, 0);
  endtask : t_traps

  task t_irqs;
    iackMode = 2'h0;
    iackVec = 8'h40;
    run_exc(CES_EXC_IRQ, 4'h0, 4'h4, 3'h3, 2'h1, 8'h40, 0, 0);
    iackVec = 8'hFF;
    ackDelay = 4'h2;
    run_exc(CES_EXC_IRQ, 4'h0, 4'h4, 3'h5, 2'h2, 8'hFF, 0, 0);
    iackMode = 2'h1;
    for (int l = 1; l < 8; l++)
      run_exc(CES_EXC_IRQ, 4'h0, 4'h0, 3'(l), 2'h0, 8'h18 + 8'(l), 0, 0);
    iackMode = 2'h2;
    run_exc(CES_EXC_IRQ, 4'h0, 4'h0, 3'h2, 2'h0, 8'h18, 0, 0);
  endtask : t_irqs

  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    end_of_test;
  end

  initial begin
    nrst = 1'b0;
    excReq = 1'b0;
    excType = CES_EXC_ACCESS;
    excTrapNum = 4'h0;
    excFaultStatus = 4'h0;
    irqLevel = 3'h0;
    faultPc = 32'h0000_4000;
    nextPc = 32'h0000_4006;
    processorStatusWordIn = 16'h9715;
    stackPointerRegIn = 32'h0000_0000;
    vectorBaseWe = 1'b0;
    vectorBaseWdata = 32'h0000_0000;
    instrRetire = 1'b0;
    ackDelay = 4'h0;
    iackMode = 2'h0;
    iackVec = 8'h40;
    failures = 0;
    samplesChecked = 0;
    mem.store[32'h0000_0000] = 32'h2000_2000;
    mem.store[32'h0000_0004] = 32'h0000_8000;
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    t_reset;
    t_faults;
    t_traps;
    t_irqs;
    end_of_test;
  end
endmodule : cpu_exception_sequencer_tb
